// ### logic/hmc_pkg.sv
/*
 * Holds the shared constants of the homing control and status block:
 * object indices, control and status bit positions, homing method codes,
 * homing progress states and the three-bit progress codes.
 * Assumes nothing of its surroundings; every other file but the synchroniser uses it by scope.
 */
package hmc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Object indices of the two words
	localparam logic [15:0] CTRL_INDEX = 16'h6040; // Control word
	localparam logic [15:0] STAT_INDEX = 16'h6041; // Status word

	////////////////////////////////////////////////////////////////////////
	// Control word bit positions
	localparam int CB_HOME_START = 4; // Homing start, acts on 0 to 1
	localparam int CB_HALT = 8; // Halt request
	localparam int CB_FAULT_RESET = 7; // Passed to the drive state machine
	localparam int CB_LOW_TOP = 3; // Bits 3..0 go to the state machine

	////////////////////////////////////////////////////////////////////////
	// Status word bit positions
	localparam int SB_TORQUE_LIMIT = 15;
	localparam int SB_HOME_ERROR = 13;
	localparam int SB_HOME_ATTAINED = 12;
	localparam int SB_INT_LIMIT = 11;
	localparam int SB_TARGET_REACHED = 10;
	localparam int SB_REMOTE = 9;
	localparam int SB_WARNING = 7;
	localparam int SB_DRIVE_TOP = 6; // Bits 6..0 come from the state machine

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Homing method codes, signed 8-bit
	localparam logic [7:0] METH_LS_NEG = 8'h11; // 17
	localparam logic [7:0] METH_LS_POS = 8'h12; // 18
	localparam logic [7:0] METH_HS_POS = 8'h18; // 24
	localparam logic [7:0] METH_HS_NEG = 8'h1c; // 28
	localparam logic [7:0] METH_PRESET_A = 8'h23; // 35
	localparam logic [7:0] METH_PRESET_B = 8'h25; // 37
	localparam logic [7:0] METH_VENDOR = 8'hff; // -1

	////////////////////////////////////////////////////////////////////////
	// Homing progress states
	typedef enum logic [1:0] {
		HM_IDLE = 2'b00, // Not started or interrupted
		HM_RUN = 2'b01, // Sequence executing
		HM_DONE = 2'b10, // Finished successfully
		HM_ALARM = 2'b11 // Aborted by an alarm
	} hmc_state_t;

	// Progress codes in the order bit13, bit12, bit10
	localparam logic [2:0] CODE_RUN = 3'h0;
	localparam logic [2:0] CODE_IDLE = 3'h1;
	localparam logic [2:0] CODE_DONE = 3'h3;
	localparam logic [2:0] CODE_ALARM = 3'h5;

endpackage

// ### logic/hmc_sync2.sv
/*
 * Two-stage synchroniser for the five asynchronous pin inputs.
 * Assumes the pins are quasi-static levels; no pulse shorter than one
 * clock period is guaranteed to be seen.
 */
`timescale 1ns/1ns
module hmc_sync2 (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [4:0] async_i,
	output logic [4:0] sync_o
);

	// First stage, read only by the second stage
	logic [4:0] meta;

	////////////////////////////////////////////////////////////////////////
	// Both stages clear on reset so nothing downstream sees X
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			meta <= 5'h00;
			sync_o <= 5'h00;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end

endmodule

// ### logic/hmc_homing_ctrl.sv
/*
 * Homing part of the motion control word and motion status word.
 * Holds the control word, runs the homing progress machine and builds
 * the status word. Assumes the fieldbus side and the drive core run on
 * clk_sys_i; the stop, travel limit and motion block pins are asynchronous.
 */
// Notes on behaviour
// - Halt bit one stops motion, else allowed
// - Homing starts only on bit 4 rising
// - Bit 4 falling mid-homing decelerates to stop
// - Start ignored when busy, halted, stopped, disabled
// - Bit 15 shows torque limit reached
// - Bit 11 shows any internal limit active
// - Bit 9 set after initialisation completes
// - Bit 7 follows warning, clears by itself
// - Running homing reports code 000
// - Idle or interrupted homing reports code 001
// - Successful homing reports code 011
// - Alarm-aborted homing reports code 101
// - Homing completion presets position to offset
// - Accept methods 17,18,24,28,35,37,-1 only
`timescale 1ns/1ns
module hmc_homing_ctrl (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic obj_wr_i, // Object write strobe
	input wire logic [15:0] obj_index_i, // Object index
	input wire logic [15:0] obj_wdata_i, // Object write data
	output logic [15:0] obj_rdata_o, // Object read data
	output logic [15:0] status_word_o, // Motion status word
	input wire logic stop_pin_i, // Stop input pin
	input wire logic [1:0] travel_limit_sensors_i, // Limit sensor pins
	input wire logic [1:0] motion_block_inputs_i, // Block input pins
	input wire logic soft_limit_i, // Software limit active
	input wire logic mech_limit_i, // Mechanical limit active
	input wire logic torque_limit_flag_i, // Torque at upper limit
	input wire logic warning_i, // Warning cause present
	input wire logic init_done_i, // Initialisation complete
	input wire logic op_enabled_i, // State machine is operation enabled
	input wire logic excited_i, // Motor excited
	input wire logic motion_busy_i, // Any motion in progress
	input wire logic home_found_i, // Profile reports home reached
	input wire logic alarm_i, // Alarm present
	input wire logic [6:0] drive_status_i, // State machine status bits
	input wire logic [7:0] homing_method_i, // Homing method object
	input wire logic [31:0] home_offset_i, // Home offset object
	output logic [4:0] drive_ctrl_o, // Bits 7,3..0 for the state machine
	output logic halt_stop_o, // Stop motion per halt option
	output logic home_start_o, // Start homing profile, pulse
	output logic home_decel_o, // Decelerate to stop, pulse
	output logic preset_strobe_o, // Position preset, pulse
	output logic [31:0] preset_value_o // Value for the preset
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [15:0] ctrl_word; // motion_control_word
	logic [4:0] pins_sync; // Synchronised pin levels
	logic start_prev; // Bit 4 of the previous cycle
	hmc_pkg::hmc_state_t state; // Homing progress
	hmc_pkg::hmc_state_t next_state;
	logic start_rise; // Bit 4 went 0 to 1
	logic start_fall; // Bit 4 went 1 to 0
	logic start_blocked; // Any reason to refuse a start
	logic stop_pin; // Synchronised stop pin
	logic any_limit; // Any internal limit active

	////////////////////////////////////////////////////////////////////////
	// Method decode used for acceptance and for preset-only methods
	function automatic logic method_ok(input logic [7:0] m);
		method_ok = (m == hmc_pkg::METH_LS_NEG) || (m == hmc_pkg::METH_LS_POS) ||
			(m == hmc_pkg::METH_HS_POS) || (m == hmc_pkg::METH_HS_NEG) ||
			(m == hmc_pkg::METH_PRESET_A) || (m == hmc_pkg::METH_PRESET_B) ||
			(m == hmc_pkg::METH_VENDOR);
	endfunction

	function automatic logic method_preset(input logic [7:0] m);
		method_preset = (m == hmc_pkg::METH_PRESET_A) || (m == hmc_pkg::METH_PRESET_B);
	endfunction

	// Progress code per state; only the four legal codes exist here
	function automatic logic [2:0] state_code(input hmc_pkg::hmc_state_t s);
		case (s)
			hmc_pkg::HM_RUN: state_code = hmc_pkg::CODE_RUN;
			hmc_pkg::HM_DONE: state_code = hmc_pkg::CODE_DONE;
			hmc_pkg::HM_ALARM: state_code = hmc_pkg::CODE_ALARM;
			default: state_code = hmc_pkg::CODE_IDLE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser: stop, two limit sensors, two block inputs
	hmc_sync2 u_sync (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i({stop_pin_i, travel_limit_sensors_i, motion_block_inputs_i}),
		.sync_o(pins_sync)
	);

	assign stop_pin = pins_sync[4];
	assign any_limit = (|pins_sync[3:0]) | soft_limit_i | mech_limit_i;

	////////////////////////////////////////////////////////////////////////
	// Control word storage; the master writes it whole
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ctrl_word <= hmc_pkg::CTRL_RESET;
		end else if (obj_wr_i && (obj_index_i == hmc_pkg::CTRL_INDEX)) begin
			ctrl_word <= obj_wdata_i;
		end
	end

	// Previous start bit, for edge detection
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= ctrl_word[hmc_pkg::CB_HOME_START];
		end
	end

	// Only an edge starts; a bit left at 1 does nothing further
	assign start_rise = ctrl_word[hmc_pkg::CB_HOME_START] & ~start_prev;
	assign start_fall = ~ctrl_word[hmc_pkg::CB_HOME_START] & start_prev;

	// Refusal is silent: the code simply stays as it was
	assign start_blocked = motion_busy_i | ctrl_word[hmc_pkg::CB_HALT] | stop_pin |
		~op_enabled_i | ~excited_i | ~method_ok(homing_method_i);

	////////////////////////////////////////////////////////////////////////
	// Homing progress machine, next state
	always_comb begin
		next_state = state;
		case (state)
			hmc_pkg::HM_RUN: begin
				if (alarm_i) begin
					next_state = hmc_pkg::HM_ALARM;
				end else if (start_fall || ctrl_word[hmc_pkg::CB_HALT]) begin
					next_state = hmc_pkg::HM_IDLE;
				end else if (home_found_i) begin
					next_state = hmc_pkg::HM_DONE;
				end
			end
			hmc_pkg::HM_IDLE, hmc_pkg::HM_DONE, hmc_pkg::HM_ALARM: begin
				if (start_rise && !start_blocked) begin
					// Preset-only methods finish at once without motion
					if (method_preset(homing_method_i)) begin
						next_state = hmc_pkg::HM_DONE;
					end else begin
						next_state = hmc_pkg::HM_RUN;
					end
				end
			end
			default: next_state = hmc_pkg::HM_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= hmc_pkg::HM_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Motion commands to the profile generator, one-cycle pulses
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			home_start_o <= 1'b0;
			home_decel_o <= 1'b0;
		end else begin
			home_start_o <= (state != hmc_pkg::HM_RUN) && (next_state == hmc_pkg::HM_RUN);
			home_decel_o <= (state == hmc_pkg::HM_RUN) && !alarm_i && start_fall;
		end
	end

	// Halt level follows the control bit; the core applies the halt option
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			halt_stop_o <= 1'b0;
		end else begin
			halt_stop_o <= ctrl_word[hmc_pkg::CB_HALT];
		end
	end

	// Position preset on completion, whether by motion or by preset method
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			preset_strobe_o <= 1'b0;
			preset_value_o <= 32'h0000_0000;
		end else begin
			// A preset method started from done must preset again, not be swallowed
			preset_strobe_o <= (next_state == hmc_pkg::HM_DONE) &&
				((state == hmc_pkg::HM_RUN) || (start_rise && !start_blocked));
			preset_value_o <= home_offset_i;
		end
	end

	// Bits owned by the drive state machine are only passed along
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			drive_ctrl_o <= 5'h00;
		end else begin
			drive_ctrl_o <= {ctrl_word[hmc_pkg::CB_FAULT_RESET],
				ctrl_word[hmc_pkg::CB_LOW_TOP:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status word assembly; one cycle behind its sources
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			status_word_o <= {5'h00, hmc_pkg::CODE_IDLE[0], 10'h000};
		end else begin
			status_word_o <= 16'h0000;
			status_word_o[hmc_pkg::SB_TORQUE_LIMIT] <= torque_limit_flag_i;
			{status_word_o[hmc_pkg::SB_HOME_ERROR], status_word_o[hmc_pkg::SB_HOME_ATTAINED],
				status_word_o[hmc_pkg::SB_TARGET_REACHED]} <= state_code(state);
			status_word_o[hmc_pkg::SB_INT_LIMIT] <= any_limit;
			status_word_o[hmc_pkg::SB_REMOTE] <= init_done_i;
			status_word_o[hmc_pkg::SB_WARNING] <= warning_i;
			status_word_o[hmc_pkg::SB_DRIVE_TOP:0] <= drive_status_i;
		end
	end

	// Read port: selected word, zero for any other index
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			obj_rdata_o <= 16'h0000;
		end else if (obj_index_i == hmc_pkg::CTRL_INDEX) begin
			obj_rdata_o <= ctrl_word;
		end else if (obj_index_i == hmc_pkg::STAT_INDEX) begin
			obj_rdata_o <= status_word_o;
		end else begin
			obj_rdata_o <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	halt_follows_a: assert property (
		ctrl_word[hmc_pkg::CB_HALT] |=> halt_stop_o)
		else $error("halt stop not raised after halt bit");
	start_edge_a: assert property (
		home_start_o |-> $past(start_rise) && !$past(start_blocked))
		else $error("homing started without a clean rising edge");
	decel_on_fall_a: assert property (
		(state == hmc_pkg::HM_RUN && start_fall && !alarm_i) |=>
		home_decel_o && state == hmc_pkg::HM_IDLE)
		else $error("no deceleration when start bit fell");
	start_refused_a: assert property (
		(state != hmc_pkg::HM_RUN && start_blocked) |=>
		!home_start_o && !preset_strobe_o && state == $past(state))
		else $error("blocked start changed homing progress");
	torque_bit_a: assert property (
		torque_limit_flag_i |=> status_word_o[hmc_pkg::SB_TORQUE_LIMIT])
		else $error("torque limit bit not set");

	limit_bit_a: assert property (
		$rose(pins_sync[3]) |=> status_word_o[hmc_pkg::SB_INT_LIMIT])
		else $error("internal limit bit not set for limit sensor");

	remote_bit_a: assert property (
		init_done_i |=> status_word_o[hmc_pkg::SB_REMOTE])
		else $error("remote bit not set after initialisation");

	warning_clear_a: assert property (
		!warning_i |=> !status_word_o[hmc_pkg::SB_WARNING])
		else $error("warning bit not cleared with cause gone");

	run_code_a: assert property (
		state == hmc_pkg::HM_RUN |=> {status_word_o[13:12], status_word_o[10]} == 3'h0)
		else $error("running homing code not 000");

	alarm_code_a: assert property (
		(state == hmc_pkg::HM_RUN && alarm_i) ##1 1'b1 |=>
		{status_word_o[13:12], status_word_o[10]} == 3'h5)
		else $error("alarm code not 101 two cycles after alarm");

	legal_code_a: assert property (
		{status_word_o[13:12], status_word_o[10]} inside {3'h0, 3'h1, 3'h3, 3'h5})
		else $error("illegal homing progress code");

	preset_done_a: assert property (
		(state == hmc_pkg::HM_RUN && home_found_i && !alarm_i && !start_fall &&
		!ctrl_word[hmc_pkg::CB_HALT]) |=> preset_strobe_o ##1
		{status_word_o[13:12], status_word_o[10]} == 3'h3)
		else $error("completion did not preset and report 011");

	method_reject_a: assert property (
		!method_ok(homing_method_i) |=> !home_start_o)
		else $error("homing started with unsupported method");

endmodule

// ### sim/hmc_master_model.sv
/*
 * Fieldbus master model: writes the control word and points reads at an object.
 * Assumes the bench calls its task by hierarchy and that the clock is shared.
 */
`timescale 1ns/1ns
module hmc_master_model (
	input wire logic clk_sys_i,
	output logic obj_wr_o,
	output logic [15:0] obj_index_o,
	output logic [15:0] obj_wdata_o
);
	////////////////////////////////////////////////////////////////////////
	// Idle: strobe low, reads aimed at the status word
	initial begin
		obj_wr_o = 1'b0;
		obj_index_o = hmc_pkg::STAT_INDEX;
		obj_wdata_o = 16'h0000;
	end

	// One access, launched after a falling edge and held across one rising edge
	task automatic access(input logic [15:0] idx, input logic [15:0] data, input logic wr);
		@(negedge clk_sys_i);
		obj_index_o = idx; // Index stays so the read keeps refreshing
		obj_wdata_o = data;
		obj_wr_o = wr; // Write strobe, high across one rising edge
		@(negedge clk_sys_i);
		obj_wr_o = 1'b0;
		// Released data shows the inverse, so stale data never looks live
		obj_wdata_o = ~data;
	endtask
endmodule

// ### sim/test_homing_mode_control_status.sv
/*
 * Self-checking bench for the homing control and status block.
 * Assumes the master model above; pulses are matched against a queue of notes.
 */
`timescale 1ns/1ns
module test_homing_mode_control_status;
	logic clk_sys_i, reset_i, obj_wr, stop_pin, soft_lim, mech_lim, torque, warn, init_done;
	logic op_en, excited, busy, found, alarm, pre;
	logic halt_stop_o, home_start_o, home_decel_o, preset_strobe_o;
	logic [15:0] obj_index, obj_wdata, obj_rdata_o, status_word_o;
	logic [1:0] tls, mbi;
	logic [6:0] dstat;
	logic [7:0] method;
	logic [31:0] offset, preset_value_o;
	logic [4:0] drive_ctrl_o;
	logic [2:0] exp_q[$]; // Notes of {start, decel, preset} pulses
	logic [15:0] seed = 16'h89e3;
	logic [7:0] meth[7] = '{hmc_pkg::METH_LS_NEG, hmc_pkg::METH_LS_POS, hmc_pkg::METH_HS_POS,
		hmc_pkg::METH_HS_NEG, hmc_pkg::METH_PRESET_A, hmc_pkg::METH_PRESET_B, hmc_pkg::METH_VENDOR};
	int error_cnt = 0;
	int checks_done = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// Clock, 8 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	hmc_master_model m (.clk_sys_i(clk_sys_i), .obj_wr_o(obj_wr), .obj_index_o(obj_index),
		.obj_wdata_o(obj_wdata));

	hmc_homing_ctrl dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .obj_wr_i(obj_wr),
		.obj_index_i(obj_index), .obj_wdata_i(obj_wdata), .obj_rdata_o(obj_rdata_o),
		.status_word_o(status_word_o), .stop_pin_i(stop_pin), .travel_limit_sensors_i(tls),
		.motion_block_inputs_i(mbi), .soft_limit_i(soft_lim), .mech_limit_i(mech_lim),
		.torque_limit_flag_i(torque), .warning_i(warn), .init_done_i(init_done),
		.op_enabled_i(op_en), .excited_i(excited), .motion_busy_i(busy), .home_found_i(found),
		.alarm_i(alarm), .drive_status_i(dstat), .homing_method_i(method),
		.home_offset_i(offset), .drive_ctrl_o(drive_ctrl_o), .halt_stop_o(halt_stop_o),
		.home_start_o(home_start_o), .home_decel_o(home_decel_o),
		.preset_strobe_o(preset_strobe_o), .preset_value_o(preset_value_o));

	////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
	endfunction

	// Expected status word from the bench's own copies of the sources
	function automatic logic [15:0] sw(input logic [2:0] code);
		return {torque, 1'b0, code[2:1], |{tls, mbi, soft_lim, mech_lim}, code[0], init_done,
			1'b0, warn, dstat};
	endfunction

	// Write the control word; a note is queued first when a start, decel or preset pulse is due
	task automatic ctl(input logic [15:0] v, input logic [2:0] note);
		if (note !== 3'h0) exp_q.push_back(note);
		m.access(hmc_pkg::CTRL_INDEX, v, 1'b1);
		cyc(3);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watcher: every pulse takes the oldest note; forbidden codes never appear
	always @(negedge clk_sys_i) begin
		logic [2:0] e;
		if (reset_i === 1'b0) begin
			if ({home_start_o, home_decel_o, preset_strobe_o} !== 3'h0) begin
				e = (exp_q.size() > 0) ? exp_q.pop_front() : 3'h0;
				chk({home_start_o, home_decel_o, preset_strobe_o}, e, "pulse");
			end
			chk({status_word_o[13:12], status_word_o[10]} inside {3'h2, 3'h4, 3'h6, 3'h7},
				1'b0, "code");
		end
	end

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			$display("unexpected at %0t: timeout", $time);
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{reset_i, stop_pin, tls, mbi, soft_lim, mech_lim, torque, warn, init_done} = 11'h400;
		{op_en, excited, busy, found, alarm, dstat} = 12'hc00;
		method = hmc_pkg::METH_LS_NEG;
		offset = 32'h0;
		repeat (5) @(negedge clk_sys_i);
		reset_i = 1'b0;
		cyc(1);
		chk(status_word_o, 16'h0400, "reset status");
		// Random flags, one limit source at a time, then none, then mech_lim alone again
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			{torque, warn, init_done, dstat} = seed[9:0];
			{tls, mbi, soft_lim, mech_lim} = 6'(6'h01 << (i % 7));
			cyc(4);
			chk(status_word_o, sw(3'h1), "flags");
			m.access(hmc_pkg::STAT_INDEX, 16'h0000, 1'b0);
			chk(obj_rdata_o, sw(3'h1), "status read");
		end
		// Status word refuses writes; state machine bits pass through
		m.access(hmc_pkg::STAT_INDEX, 16'hffff, 1'b1);
		cyc(1);
		chk(drive_ctrl_o, 5'h00, "status write refused");
		ctl(16'h0085, 3'h0);
		chk(drive_ctrl_o, 5'h15, "drive bits");
		m.access(hmc_pkg::CTRL_INDEX, 16'h0000, 1'b0);
		chk(obj_rdata_o, 16'h0085, "ctrl read");
		m.access(16'h1234, 16'h0000, 1'b0);
		chk(obj_rdata_o, 16'h0000, "unmapped read");
		ctl(16'h0000, 3'h0);
		// Every method: searches start the profile, presets go straight to done
		foreach (meth[k]) begin
			method = meth[k];
			seed = lfsr(seed);
			offset = {seed, ~seed};
			pre = (k == 4 || k == 5);
			ctl(16'h0010, pre ? 3'h1 : 3'h4);
			if (!pre) begin
				chk(status_word_o, sw(3'h0), "running");
				exp_q.push_back(3'h1);
				found = 1'b1;
				cyc(1);
				found = 1'b0;
				cyc(3);
			end
			ctl(16'h0010, 3'h0);
			chk(status_word_o, sw(3'h3), "homed");
			chk(preset_value_o, offset, "preset value");
			ctl(16'h0000, 3'h0);
		end
		// Each blocking cause, then a method outside the accepted set
		for (int b = 0; b < 6; b++) begin
			{busy, stop_pin, op_en, excited} = {b == 0, b == 1, b != 2, b != 3};
			method = (b == 5) ? 8'h13 : hmc_pkg::METH_LS_NEG;
			cyc(4);
			ctl((b == 4) ? 16'h0110 : 16'h0010, 3'h0);
			chk(status_word_o, sw(3'h3), "blocked");
			ctl(16'h0000, 3'h0);
		end
		{busy, stop_pin, op_en, excited, method} = {4'h3, hmc_pkg::METH_LS_NEG};
		cyc(4);
		// Abort by clearing the start bit
		ctl(16'h0010, 3'h4);
		ctl(16'h0000, 3'h2);
		chk(status_word_o, sw(3'h1), "aborted");
		// Halt in mid-run interrupts without a decel pulse
		ctl(16'h0010, 3'h4);
		ctl(16'h0110, 3'h0);
		chk(status_word_o, sw(3'h1), "halted");
		chk(halt_stop_o, 1'b1, "halt level");
		ctl(16'h0000, 3'h0);
		chk(halt_stop_o, 1'b0, "halt released");
		// Alarm aborts and sticks until a new start
		ctl(16'h0010, 3'h4);
		alarm = 1'b1;
		cyc(3);
		chk(status_word_o, sw(3'h5), "alarm");
		ctl(16'h0000, 3'h0);
		alarm = 1'b0;
		cyc(3);
		chk(status_word_o, sw(3'h5), "alarm held");
		ctl(16'h0010, 3'h4);
		chk(status_word_o, sw(3'h0), "restart");
		ctl(16'h0000, 3'h2);
		cyc(4);
		// Reset in mid-run drops homing back to idle; a fresh start works
		ctl(16'h0010, 3'h4);
		reset_i = 1'b1;
		cyc(3);
		reset_i = 1'b0;
		cyc(4);
		chk(status_word_o, sw(3'h1), "mid-run reset");
		ctl(16'h0010, 3'h4);
		chk(status_word_o, sw(3'h0), "run after reset");
		chk(exp_q.size(), 0, "pending pulses");
		test_done();
	end
endmodule
